// ---- smbus_defs.svh ----
// shared constants for the smbus slave end and the smbus host end
`ifndef SMBUS_DEFS_SVH
`define SMBUS_DEFS_SVH
`define CLK_PERIOD_NS 5
`define DEV_ADDR_FIXED 7'h2E
`define DEV_ADDR_STRAP_HI 6'h16
`define ARA_ADDR 7'h0C
`define CFG_ONE_OFFSET 8'h40
`define CFG_ONE_RESET 8'h00
`define CFG_TO_OFF_BIT 6
`define TIMEOUT_MS 35
`define TIMEOUT_CYCLES (`TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)
`define SCL_PERIOD_NS 10000
`define SCL_QUARTER_CYCLES (`SCL_PERIOD_NS / 4 / `CLK_PERIOD_NS)
`define HREG_CTRL 12'h000
`define HREG_TARGET 12'h004
`define HREG_CMD 12'h008
`define HREG_WDATA 12'h00C
`define HREG_RDATA 12'h010
`define HREG_STATUS 12'h014
`define HREG_MASK 12'h018
`define ST_DONE 0
`define ST_NACK 1
`define ST_ALERT 2
`define ST_BUSY 8
`endif

// ---- smbus_pkg.sv ----
// types shared by both smbus ends
package smbus_pkg;
  typedef enum logic [2:0] {OP_SEND, OP_WRITE, OP_RECV, OP_SEND_RECV, OP_ARA} host_op_t;
  typedef enum logic [1:0] {K_TX, K_RX, K_RSTART, K_STOP} step_kind_t;
  typedef enum {D_IDLE, D_ADDR, D_ACK, D_RX, D_TX, D_TXACK, D_IGNORE} dev_state_t;
  typedef enum {H_IDLE, H_START, H_BYTE, H_STOP} host_state_t;
endpackage

// ---- smbus_if.sv ----
// two-wire bus joining the host end and the slave end
`timescale 1ns/1ps
interface smbus_if;
  logic scl_host_o;
  logic scl_host_oe_b;
  logic sda_host_o;
  logic sda_host_oe_b;
  logic sda_dev_o;
  logic sda_dev_oe_b;
  logic alert_b;
  logic scl;
  logic sda;
  // open-drain wired-and, pulled high when nobody drives
  assign scl = !(!scl_host_oe_b && !scl_host_o);
  assign sda = !((!sda_host_oe_b && !sda_host_o) || (!sda_dev_oe_b && !sda_dev_o));
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe_b, output alert_b);
  modport host (input scl, input sda, input alert_b, output scl_host_o, output scl_host_oe_b,
    output sda_host_o, output sda_host_oe_b);
endinterface

// ---- smbus_slave_end.sv ----
// smbus slave end: address match, pointer, register access, alert response, timeout
//
// The register file port was decided locally.
`timescale 1ns/1ps
// Functional notes
// - direction fixed by r/w bit per operation
// - writes carry one or two bytes; reads one
// - first written byte loads register pointer
// - second written byte goes to pointed register
// - bare read returns currently pointed register
// - repeated start begins a new operation
// - send byte: addr w, ack, index, ack, stop
// - write byte: addr, index, data, each acked
// - receive byte: addr r, ack, data, nack, stop
// - repeated start read after send byte allowed
// - answer alert response address while alerting
// - arbitrate while returning own address
// - alert released only once condition gone
// - 35 ms bus inactivity abandons the transfer
// - config bit 6 set disables the timeout
// - default slave address 0x2E
// - strap address frozen on first matching access
`include "smbus_defs.svh"
module smbus_slave_end
  import smbus_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // bus pins
  smbus_if.device bus,
  // address straps
  input wire logic i_addr_strap_mode,
  input wire logic i_addr_strap_lsb,
  // alert cause from monitoring logic
  input wire logic i_alert_cond,
  // register file port
  output logic o_reg_wr,
  output logic [7:0] o_reg_ptr,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata,
  // configuration
  output logic [7:0] o_config_one,
  output logic o_bus_timeout_off
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  dev_state_t state_q;
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [1:0] mode_sync_q;
  logic [1:0] lsb_sync_q;
  logic [6:0] addr_q;
  logic lock_q;
  logic [3:0] cnt_q;
  logic [7:0] shreg_q;
  logic [1:0] idx_q;
  logic rw_q;
  logic ara_q;
  logic sda_oe_b_q;
  logic alert_b_q;
  logic ara_seen_q;
  logic [7:0] ptr_q;
  logic [7:0] cfg_q;
  logic [7:0] wdata_q;
  logic reg_wr_q;
  logic [TW-1:0] idle_cnt_q;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic timeout_ev;
  logic addr_done;
  logic own_hit;
  logic ara_hit;
  logic rx_done;
  logic ara_done;
  logic [7:0] tx_byte;

  // pins pass two flops; [2] keeps history for edge detection
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      mode_sync_q <= 2'h0;
      lsb_sync_q <= 2'h0;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], bus.scl};
      sda_sync_q <= {sda_sync_q[1:0], bus.sda};
      mode_sync_q <= {mode_sync_q[0], i_addr_strap_mode};
      lsb_sync_q <= {lsb_sync_q[0], i_addr_strap_lsb};
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign scl_rise = scl_s && !scl_sync_q[2];
  assign scl_fall = !scl_s && scl_sync_q[2];
  assign start_ev = scl_s && scl_sync_q[2] && sda_sync_q[2] && !sda_s;
  assign stop_ev = scl_s && scl_sync_q[2] && !sda_sync_q[2] && sda_s;
  assign addr_done = (state_q == D_ADDR) && scl_fall && (cnt_q == 4'h8);
  assign own_hit = (shreg_q[7:1] == addr_q);
  assign ara_hit = (shreg_q[7:1] == `ARA_ADDR) && shreg_q[0] && !alert_b_q;
  assign rx_done = (state_q == D_RX) && scl_fall && (cnt_q == 4'h8);
  assign ara_done = (state_q == D_TX) && scl_fall && (cnt_q == 4'h8) && ara_q;
  // pointer is only read here, never stepped
  assign tx_byte = ara_q ? {addr_q, 1'b0} :
    ((ptr_q == `CFG_ONE_OFFSET) ? cfg_q : i_reg_rdata);
  assign timeout_ev = (state_q != D_IDLE) && !cfg_q[`CFG_TO_OFF_BIT] &&
    (idle_cnt_q == TW'(TIMEOUT_CYCLES - 1));

  // slave address follows straps until the first match
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      addr_q <= `DEV_ADDR_FIXED;
      lock_q <= 1'b0;
    end
    else if (!lock_q)
    begin
      addr_q <= mode_sync_q[1] ? {`DEV_ADDR_STRAP_HI, lsb_sync_q[1]} : `DEV_ADDR_FIXED;
      if (addr_done && own_hit)
        lock_q <= 1'b1;
    end
  end

  // inactivity counter, cleared by any line change
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      idle_cnt_q <= '0;
    else if (state_q == D_IDLE || (scl_s != scl_sync_q[2]) || (sda_s != sda_sync_q[2]))
      idle_cnt_q <= '0;
    else if (!timeout_ev)
      idle_cnt_q <= idle_cnt_q + 1'b1;
  end

  // byte-level bus engine
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      state_q <= D_IDLE;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
      sda_oe_b_q <= 1'b1;
    end
    else if (start_ev)
    begin
      state_q <= D_ADDR;
      cnt_q <= 4'h0;
      idx_q <= 2'h0;
      sda_oe_b_q <= 1'b1;
    end
    else if (stop_ev || timeout_ev)
    begin
      state_q <= D_IDLE;
      sda_oe_b_q <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        D_IDLE, D_IGNORE:
          sda_oe_b_q <= 1'b1;
        D_ADDR, D_RX:
          if (scl_rise)
          begin
            shreg_q <= {shreg_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            cnt_q <= 4'h0;
            if (state_q == D_ADDR && (own_hit || ara_hit))
            begin
              rw_q <= shreg_q[0];
              ara_q <= ara_hit;
              state_q <= D_ACK;
              sda_oe_b_q <= 1'b0;
            end
            else if (state_q == D_RX && idx_q != 2'h2)
            begin
              idx_q <= idx_q + 2'h1;
              state_q <= D_ACK;
              sda_oe_b_q <= 1'b0;
            end
            else
              state_q <= D_IGNORE;
          end
        D_ACK:
          if (scl_fall)
          begin
            cnt_q <= 4'h0;
            if (rw_q)
            begin
              shreg_q <= tx_byte;
              sda_oe_b_q <= tx_byte[7];
              state_q <= D_TX;
            end
            else
            begin
              sda_oe_b_q <= 1'b1;
              state_q <= D_RX;
            end
          end
        D_TX:
          if (scl_rise)
          begin
            cnt_q <= cnt_q + 4'h1;
            // sent a one but line reads low: lost arbitration
            if (sda_oe_b_q && !sda_s)
              state_q <= D_IGNORE;
          end
          else if (scl_fall)
          begin
            if (cnt_q == 4'h8)
            begin
              sda_oe_b_q <= 1'b1;
              state_q <= D_TXACK;
            end
            else
            begin
              shreg_q <= {shreg_q[6:0], 1'b0};
              sda_oe_b_q <= shreg_q[6];
            end
          end
        D_TXACK:
          if (scl_rise)
            state_q <= D_IGNORE;
      endcase
    end
  end

  // pointer, config and register writes
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      ptr_q <= 8'h00;
      cfg_q <= `CFG_ONE_RESET;
      wdata_q <= 8'h00;
      reg_wr_q <= 1'b0;
    end
    else
    begin
      reg_wr_q <= rx_done && (idx_q == 2'h1);
      if (rx_done && idx_q == 2'h0)
        ptr_q <= shreg_q;
      if (rx_done && idx_q == 2'h1)
      begin
        wdata_q <= shreg_q;
        if (ptr_q == `CFG_ONE_OFFSET)
          cfg_q <= shreg_q;
      end
    end
  end

  // alert held until answered and condition gone
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      alert_b_q <= 1'b1;
      ara_seen_q <= 1'b0;
    end
    else
    begin
      if (ara_done)
        ara_seen_q <= 1'b1;
      else if (alert_b_q)
        ara_seen_q <= 1'b0;
      if (i_alert_cond)
        alert_b_q <= 1'b0;
      else if (ara_done || ara_seen_q)
        alert_b_q <= 1'b1;
    end
  end

  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe_b = sda_oe_b_q;
  assign bus.alert_b = alert_b_q;
  assign o_reg_wr = reg_wr_q;
  assign o_reg_ptr = ptr_q;
  assign o_reg_wdata = wdata_q;
  assign o_config_one = cfg_q;
  assign o_bus_timeout_off = cfg_q[`CFG_TO_OFF_BIT];
endmodule

// ---- smbus_host_end.sv ----
// smbus host end: apb command registers driving send, write, receive and alert reads
`timescale 1ns/1ps
`include "smbus_defs.svh"
module smbus_host_end
  import smbus_pkg::*;
#(
  parameter int SCL_QUARTER = `SCL_QUARTER_CYCLES
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // interrupt
  output logic o_irq,
  // bus pins
  smbus_if.host bus
);
  host_state_t state_q;
  host_op_t op_q;
  logic [6:0] target_q;
  logic [7:0] cmd_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic [1:0] sda_sync_q;
  logic [2:0] alert_sync_q;
  logic [15:0] qcnt_q;
  logic [1:0] qt_q;
  logic [3:0] bit_q;
  logic [2:0] idx_q;
  logic [7:0] shreg_q;
  logic rx_q;
  logic nack_q;
  logic scl_oe_b_q;
  logic sda_oe_b_q;
  logic busy;
  logic tick;
  logic wr_acc;
  logic go;
  logic done_ev;
  logic nack_ev;
  logic [2:0] nidx;
  step_kind_t nk;

  function automatic logic addr_ok(input logic [11:0] a);
    return a == `HREG_CTRL || a == `HREG_TARGET || a == `HREG_CMD || a == `HREG_WDATA ||
      a == `HREG_RDATA || a == `HREG_STATUS || a == `HREG_MASK;
  endfunction

  function automatic step_kind_t step_kind(input host_op_t op, input logic [2:0] i);
    unique case (op)
      OP_SEND: return (i < 3'h2) ? K_TX : K_STOP;
      OP_WRITE: return (i < 3'h3) ? K_TX : K_STOP;
      OP_SEND_RECV: return (i < 3'h2 || i == 3'h3) ? K_TX :
        (i == 3'h2) ? K_RSTART : (i == 3'h4) ? K_RX : K_STOP;
      default: return (i == 3'h0) ? K_TX : (i == 3'h1) ? K_RX : K_STOP;
    endcase
  endfunction

  function automatic logic [7:0] step_byte(input host_op_t op, input logic [2:0] i,
    input logic [6:0] t, input logic [7:0] c, input logic [7:0] d);
    if (i == 3'h0)
      return (op == OP_ARA) ? {`ARA_ADDR, 1'b1} : {t, op == OP_RECV};
    else if (i == 3'h1)
      return c;
    else if (i == 3'h2)
      return d;
    else
      return {t, 1'b1};
  endfunction

  assign busy = state_q != H_IDLE;
  assign tick = busy && (qcnt_q == 16'(SCL_QUARTER - 1));
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign go = wr_acc && i_paddr == `HREG_CTRL && !busy;
  assign nidx = idx_q + 3'h1;
  assign nk = step_kind(op_q, nidx);
  assign done_ev = (state_q == H_STOP) && tick && qt_q == 2'h3;
  assign nack_ev = (state_q == H_BYTE) && tick && qt_q == 2'h3 && bit_q == 4'h8 && nack_q;

  // apb: zero wait states, read data captured in setup
  assign o_pready = i_psel && i_penable;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end
    else if (i_psel && !i_penable)
    begin
      slverr_q <= !addr_ok(i_paddr);
      unique case (i_paddr)
        `HREG_CTRL: prdata_q <= {29'h0, op_q};
        `HREG_TARGET: prdata_q <= {25'h0, target_q};
        `HREG_CMD: prdata_q <= {24'h0, cmd_q};
        `HREG_WDATA: prdata_q <= {24'h0, wdata_q};
        `HREG_RDATA: prdata_q <= {24'h0, rdata_q};
        `HREG_STATUS: prdata_q <= {23'h0, busy, 5'h0, status_q};
        `HREG_MASK: prdata_q <= {29'h0, mask_q};
        default: prdata_q <= 32'h0;
      endcase
    end
  end
  assign o_prdata = prdata_q;
  assign o_pslverr = slverr_q;

  // software registers; event sets win over w1c
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      target_q <= `DEV_ADDR_FIXED;
      cmd_q <= 8'h00;
      wdata_q <= 8'h00;
      mask_q <= 3'h0;
      status_q <= 3'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr_acc && i_paddr == `HREG_TARGET)
        target_q <= i_pwdata[6:0];
      if (wr_acc && i_paddr == `HREG_CMD)
        cmd_q <= i_pwdata[7:0];
      if (wr_acc && i_paddr == `HREG_WDATA)
        wdata_q <= i_pwdata[7:0];
      if (wr_acc && i_paddr == `HREG_MASK)
        mask_q <= i_pwdata[2:0];
      status_q <= (status_q & ~((wr_acc && i_paddr == `HREG_STATUS) ? i_pwdata[2:0] : 3'h0))
        | {alert_sync_q[2] && !alert_sync_q[1], nack_ev, done_ev};
      irq_q <= |(status_q & mask_q);
    end
  end
  assign o_irq = irq_q;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      sda_sync_q <= 2'h3;
      alert_sync_q <= 3'h7;
      qcnt_q <= 16'h0;
    end
    else
    begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      alert_sync_q <= {alert_sync_q[1:0], bus.alert_b};
      qcnt_q <= (!busy || tick) ? 16'h0 : qcnt_q + 16'h1;
    end
  end

  // bit sequencer, four quarter periods per scl cycle
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      state_q <= H_IDLE;
      op_q <= OP_SEND;
      qt_q <= 2'h0;
      bit_q <= 4'h0;
      idx_q <= 3'h0;
      shreg_q <= 8'h00;
      rx_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 8'h00;
      scl_oe_b_q <= 1'b1;
      sda_oe_b_q <= 1'b1;
    end
    else if (go)
    begin
      op_q <= host_op_t'(i_pwdata[2:0]);
      state_q <= H_START;
      idx_q <= 3'h0;
      qt_q <= 2'h0;
    end
    else if (tick)
    begin
      qt_q <= qt_q + 2'h1;
      unique case (state_q)
        H_IDLE: ;
        H_START:
          unique case (qt_q)
            2'h0: sda_oe_b_q <= 1'b1;
            2'h1: scl_oe_b_q <= 1'b1;
            2'h2: sda_oe_b_q <= 1'b0;
            2'h3:
            begin
              scl_oe_b_q <= 1'b0;
              state_q <= H_BYTE;
              bit_q <= 4'h0;
              shreg_q <= step_byte(op_q, idx_q, target_q, cmd_q, wdata_q);
              rx_q <= step_kind(op_q, idx_q) == K_RX;
            end
          endcase
        H_BYTE:
          unique case (qt_q)
            // ninth bit released: ack from slave, or nack ending a read
            2'h0: sda_oe_b_q <= (bit_q == 4'h8 || rx_q) ? 1'b1 : shreg_q[7];
            2'h1: scl_oe_b_q <= 1'b1;
            2'h2:
              if (bit_q == 4'h8)
                nack_q <= sda_sync_q[1] && !rx_q;
              else
                shreg_q <= {shreg_q[6:0], sda_sync_q[1]};
            2'h3:
            begin
              scl_oe_b_q <= 1'b0;
              bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
              if (bit_q == 4'h8)
              begin
                if (rx_q)
                  rdata_q <= shreg_q;
                idx_q <= (nk == K_RSTART) ? idx_q + 3'h2 : nidx;
                if (nack_q || nk == K_STOP)
                  state_q <= H_STOP;
                else if (nk == K_RSTART)
                  state_q <= H_START;
                else
                begin
                  shreg_q <= step_byte(op_q, nidx, target_q, cmd_q, wdata_q);
                  rx_q <= nk == K_RX;
                end
              end
            end
          endcase
        H_STOP:
          unique case (qt_q)
            2'h0: sda_oe_b_q <= 1'b0;
            2'h1: scl_oe_b_q <= 1'b1;
            2'h2: sda_oe_b_q <= 1'b1;
            2'h3: state_q <= H_IDLE;
          endcase
      endcase
    end
  end

  assign bus.scl_host_o = 1'b0;
  assign bus.scl_host_oe_b = scl_oe_b_q;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe_b = sda_oe_b_q;
endmodule

// ---- smbus_link_asserts.sv ----
// concurrent checks on the smbus link between the host end and the slave end
`timescale 1ns/1ps
`include "smbus_defs.svh"
module smbus_link_asserts (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe_b,
  input wire logic alert_b,
  // slave end side
  input wire logic i_alert_cond,
  input wire logic o_reg_wr,
  input wire logic [7:0] o_reg_ptr,
  input wire logic [7:0] o_reg_wdata,
  input wire logic [7:0] o_config_one,
  input wire logic o_bus_timeout_off
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  a_alert_follows_cause: assert property ($rose(i_alert_cond) |-> ##[1:4] !alert_b)
    else $error("alert did not assert after its cause");
  a_alert_held_low: assert property (i_alert_cond && !alert_b |=> !alert_b)
    else $error("alert released while its cause stands");
  a_alert_needs_cause: assert property ($fell(alert_b) |->
    $past(i_alert_cond) || $past(i_alert_cond, 2) || $past(i_alert_cond, 3))
    else $error("alert asserted without a cause");
  a_alert_release_clean: assert property ($rose(alert_b) |-> !$past(i_alert_cond))
    else $error("alert released with cause still high");
  a_drive_in_low: assert property ($fell(sda_dev_oe_b) |-> !scl)
    else $error("slave began driving data while clock high");
  a_wr_single_pulse: assert property (o_reg_wr |=> !o_reg_wr)
    else $error("register write strobe longer than one cycle");
  a_wr_in_low: assert property (o_reg_wr |-> !scl)
    else $error("register write outside clock low phase");
  a_ptr_moves_in_low: assert property ($changed(o_reg_ptr) |-> !scl)
    else $error("pointer changed while clock high");
  a_cfg_write_lands: assert property (o_reg_wr && o_reg_ptr == `CFG_ONE_OFFSET |->
    ##[0:2] o_config_one == o_reg_wdata)
    else $error("config write not stored");
  a_cfg_bit_follows: assert property ($changed(o_bus_timeout_off) |->
    o_reg_wr && o_reg_ptr == `CFG_ONE_OFFSET)
    else $error("timeout disable changed without a config write");

  c_start_seen: cover property ($fell(sda) && scl);
  c_reg_written: cover property (o_reg_wr);
  c_alert_released: cover property ($rose(alert_b));
endmodule

// ---- tb_top.sv ----
// self-checking bench: apb commands through the host end to the slave end
`timescale 1ns/1ps
`include "smbus_defs.svh"
module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic alert_cond = 1'b0;
  logic strap_mode = 1'b0;
  logic reg_wr;
  logic [7:0] reg_ptr;
  logic [7:0] reg_wdata;
  logic [7:0] config_one;
  logic bus_timeout_off;
  logic [7:0] regs [256];
  logic [7:0] sh = 8'h00;
  logic [7:0] first_byte = 8'h00;
  logic [31:0] d;
  logic [31:0] st;
  logic e;
  int nbits = 0;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  smbus_if bus ();
  // shortened scl quarter keeps the run short
  smbus_host_end #(.SCL_QUARTER(100)) i_smbus_host_end (.i_clock(clock), .i_rst_b(rst_b),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .bus(bus));
  smbus_slave_end #(.TIMEOUT_CYCLES(5000)) i_smbus_slave_end (.i_clock(clock), .i_rst_b(rst_b),
    .bus(bus), .i_addr_strap_mode(strap_mode), .i_addr_strap_lsb(1'b0),
    .i_alert_cond(alert_cond),
    .o_reg_wr(reg_wr), .o_reg_ptr(reg_ptr), .o_reg_wdata(reg_wdata),
    .i_reg_rdata(regs[reg_ptr]), .o_config_one(config_one),
    .o_bus_timeout_off(bus_timeout_off));
  smbus_link_asserts i_smbus_link_asserts (.i_clock(clock), .i_rst_b(rst_b), .scl(bus.scl),
    .sda(bus.sda), .sda_dev_oe_b(bus.sda_dev_oe_b), .alert_b(bus.alert_b),
    .i_alert_cond(alert_cond), .o_reg_wr(reg_wr), .o_reg_ptr(reg_ptr),
    .o_reg_wdata(reg_wdata), .o_config_one(config_one), .o_bus_timeout_off(bus_timeout_off));

  // register file behind the slave end
  always @(posedge clock)
    if (reg_wr === 1'b1) regs[reg_ptr] <= reg_wdata;

  // line monitor: first byte after each start, msb first
  always @(negedge bus.sda)
    if (bus.scl) nbits = 0;
  always @(posedge bus.scl)
  begin
    sh = {sh[6:0], bus.sda};
    nbits++;
    if (nbits == 8) first_byte = sh;
  end

  task automatic stop_test;
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, v, r, x);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic x;
    apb(1'b0, a, 32'h0, v, x);
  endtask

  // start a bus operation, wait for done, clear status
  task automatic op(input logic [2:0] code, output logic [31:0] s);
    wr(`HREG_CTRL, 32'(code));
    s = 32'h0;
    while (s[0] !== 1'b1) rd(`HREG_STATUS, s);
    wr(`HREG_STATUS, 32'h7);
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      errors++;
      $display("[ERR] %0t run did not complete", $time);
      stop_test();
    end
  end

  initial
  begin
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5A;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`HREG_TARGET, d);
    check(d, 32'h2E);
    rd(`HREG_MASK, d);
    check(d, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0, d, e);
    check({d[30:0], e}, 32'h1);
    check(32'(config_one), 32'(`CFG_ONE_RESET));
    wr(`HREG_CMD, 32'h10);
    wr(`HREG_WDATA, 32'hA5);
    op(3'd1, st);
    // address now locked: a later strap change must not move it
    strap_mode <= 1'b1;
    check(st[1], 1'b0);
    check(32'(first_byte), 32'h5C);
    check(32'(reg_ptr), 32'h10);
    check(32'(regs[8'h10]), 32'hA5);
    repeat (2)
    begin
      op(3'd2, st);
      check(st[1], 1'b0);
      rd(`HREG_RDATA, d);
      check(d, 32'hA5);
      check(32'(first_byte), 32'h5D);
      check(32'(reg_ptr), 32'h10);
    end
    wr(`HREG_CMD, 32'h20);
    op(3'd3, st);
    rd(`HREG_RDATA, d);
    check(d, 32'h7A);
    check(32'(reg_ptr), 32'h20);
    wr(`HREG_TARGET, 32'h2F);
    wr(`HREG_CMD, 32'h30);
    op(3'd0, st);
    check(st[1], 1'b1);
    check(32'(reg_ptr), 32'h20);
    wr(`HREG_TARGET, 32'h2E);
    op(3'd4, st);
    check(st[1], 1'b1);
    alert_cond <= 1'b1;
    repeat (10) @(posedge clock);
    check(bus.alert_b, 1'b0);
    rd(`HREG_STATUS, d);
    check(d[2], 1'b1);
    check(irq, 1'b0);
    wr(`HREG_MASK, 32'h4);
    @(posedge clock);
    check(irq, 1'b1);
    alert_cond <= 1'b0;
    repeat (10) @(posedge clock);
    check(bus.alert_b, 1'b0);
    alert_cond <= 1'b1;
    op(3'd4, st);
    check(st[1], 1'b0);
    rd(`HREG_RDATA, d);
    check(d, 32'h5C);
    check(irq, 1'b0);
    check(bus.alert_b, 1'b0);
    alert_cond <= 1'b0;
    repeat (10) @(posedge clock);
    check(bus.alert_b, 1'b1);
    wr(`HREG_CMD, 32'h40);
    wr(`HREG_WDATA, 32'h40);
    op(3'd1, st);
    check(32'(config_one), 32'h40);
    check(bus_timeout_off, 1'b1);
    wr(`HREG_CMD, 32'h30);
    op(3'd0, st);
    check(st[1], 1'b0);
    check(32'(reg_ptr), 32'h30);
    stop_test();
  end
endmodule
